// file: sfp_device.sv
// device end: four fifo threads behind the slave port, on the link clock
// assumes a user side on sys_clk that drains producer and fills consumer threads
`timescale 1ns/100ps
module sfp_device
  import sfp_pkg::*;
(
  sfp_link_if.device        link,
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic         linkRst,
  input  sfp_flag_mode_t    flagAMode,
  input  wire logic         flagADedicated,
  input  wire logic [THR_W-1:0] flagAThread,
  input  sfp_flag_mode_t    flagBMode,
  input  wire logic         wideSocketMode,
  output logic              commitToggle,
  output logic [THR_W-1:0]  commitThread,
  output logic [CNT_W-1:0]  commitCount
);
  import sfp_pkg::*;
  sfp_word_t                mem [THREADS][DEPTH];
  logic [PTR_W-1:0]         rdPtr_reg [THREADS];
  logic [PTR_W-1:0]         wrPtr_reg [THREADS];
  logic [CNT_W-1:0]         cnt_reg [THREADS];
  logic [CNT_W-1:0]         cntSeen_reg [THREADS];
  logic [THR_W-1:0]         thr_reg, thr_next;
  logic [2:0]               swCnt_reg, swCnt_next;
  logic                     ready_reg, ready_next;
  logic                     flagA_reg, flagB_reg;
  logic                     cfgSync1_reg, cfgSync2_reg;
  logic                     commitToggle_reg;
  logic [THR_W-1:0]         commitThread_reg;
  logic [CNT_W-1:0]         commitCount_reg;
  logic                     cs, rd, wr, oe, sw, pe;
  assign cs = !link.portChipSelectN;
  assign rd = cs && !link.portReadStrobeN;
  assign wr = cs && !link.portWriteStrobeN;
  assign oe = cs && !link.portOutputEnableN;
  assign sw = cs && !link.socketSwitchStrobeN;
  assign pe = cs && !link.packetCommitStrobeN;
  // wide mode strap crosses into link domain
  always_ff @(posedge link.linkClk) begin
    cfgSync1_reg <= wideSocketMode;
    cfgSync2_reg <= cfgSync1_reg;
  end
  function automatic logic flagOf(sfp_flag_mode_t m, logic [CNT_W-1:0] c);
    unique case (m)
      FLAG_EMPTY:   flagOf = (c != '0);
      FLAG_FULL:    flagOf = (c != CNT_W'(DEPTH));
      FLAG_PARTIAL: flagOf = (c < PARTIAL_LEVEL);
      default:      flagOf = 1'b0;
    endcase
  endfunction : flagOf
  // thread select and switching delay
  always_comb begin
    thr_next   = thr_reg;
    swCnt_next = (swCnt_reg != '0) ? swCnt_reg - 3'h1 : swCnt_reg;
    ready_next = (swCnt_reg <= 3'h1);
    if (!cfgSync2_reg) begin
      thr_next   = link.fifoSelectLines[THR_W-1:0];
      swCnt_next = '0;
      ready_next = 1'b1;
    end else if (sw) begin
      thr_next   = link.fifoSelectLines[THR_W-1:0];
      swCnt_next = 3'(SWITCH_DELAY);
      ready_next = 1'b0;
    end
  end
  always_ff @(posedge link.linkClk) begin
    if (linkRst) begin
      thr_reg   <= '0;
      swCnt_reg <= '0;
      ready_reg <= 1'b1;
    end else begin
      thr_reg   <= thr_next;
      swCnt_reg <= swCnt_next;
      ready_reg <= ready_next;
    end
  end
  // fifo storage and pointers
  always_ff @(posedge link.linkClk) begin
    for (int t = 0; t < THREADS; t++) begin
      if (linkRst) begin
        rdPtr_reg[t] <= '0;
        wrPtr_reg[t] <= '0;
        cnt_reg[t]   <= '0;
      end else if (THR_W'(t) == thr_reg) begin
        if (wr && cnt_reg[t] != CNT_W'(DEPTH)) begin
          mem[t][wrPtr_reg[t]] <= link.dataBus;
          wrPtr_reg[t] <= wrPtr_reg[t] + 3'h1;
        end
        if (rd && cnt_reg[t] != '0)
          rdPtr_reg[t] <= rdPtr_reg[t] + 3'h1;
        cnt_reg[t] <= cnt_reg[t] + CNT_W'(wr && cnt_reg[t] != CNT_W'(DEPTH))
                      - CNT_W'(rd && cnt_reg[t] != '0);
      end
    end
  end
  // flags lag the fill count by a fixed delay
  always_ff @(posedge link.linkClk) begin
    for (int t = 0; t < THREADS; t++)
      cntSeen_reg[t] <= linkRst ? '0 : cnt_reg[t];
    flagA_reg <= linkRst ? 1'b0 : flagOf(flagAMode, cntSeen_reg[flagADedicated ? flagAThread : thr_reg]);
    flagB_reg <= linkRst ? 1'b0 : flagOf(flagBMode, cntSeen_reg[thr_reg]);
  end
  assign link.flagA       = flagA_reg;
  assign link.flagB       = flagB_reg;
  // producer ready when room, consumer ready when data
  assign link.threadReady = ready_reg && (thr_reg[0] ? cnt_reg[thr_reg] != '0
                                                     : cnt_reg[thr_reg] != CNT_W'(DEPTH));
  // oe drives only, current word shown at once
  assign link.deviceDataOe  = oe;
  assign link.dataFromDevice = mem[thr_reg][rdPtr_reg[thr_reg]];
  // packet commit: short packet or zero length
  always_ff @(posedge link.linkClk) begin
    if (linkRst) begin
      commitToggle_reg <= 1'b0;
      commitThread_reg <= '0;
      commitCount_reg  <= '0;
    end else if (pe) begin
      commitToggle_reg <= !commitToggle_reg;
      commitThread_reg <= thr_reg;
      commitCount_reg  <= wr ? cnt_reg[thr_reg] + 4'h1 : cnt_reg[thr_reg];
    end
  end
  // commit event handed to sys_clk by toggle
  logic tgl1_reg, tgl2_reg, tgl3_reg;
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tgl1_reg <= 1'b0;
      tgl2_reg <= 1'b0;
      tgl3_reg <= 1'b0;
      commitThread <= '0;
      commitCount  <= '0;
    end else begin
      tgl1_reg <= commitToggle_reg;
      tgl2_reg <= tgl1_reg;
      tgl3_reg <= tgl2_reg;
      if (tgl2_reg != tgl3_reg) begin
        commitThread <= commitThread_reg;
        commitCount  <= commitCount_reg;
      end
    end
  end
  assign commitToggle = tgl3_reg;
endmodule : sfp_device

// file: sfp_host.sv
// host end: master that reads, writes, commits and switches sockets
// assumes a user command on sys_clk held until done rises; done stays high until cmdValid drops
`timescale 1ns/100ps
module sfp_host
  import sfp_pkg::*;
(
  sfp_link_if.host          link,
  input  wire logic         sys_clk,
  input  wire logic         sys_rst,
  input  wire logic [1:0]   cmdOp,
  input  wire logic         cmdValid,
  input  wire logic [ADDR_W-1:0] cmdAddr,
  input  sfp_word_t         cmdData,
  input  wire logic         cmdCommit,
  output logic              cmdDone,
  output sfp_word_t         rdData
);
  import sfp_pkg::*;
  typedef enum logic [4:0] {S_IDLE  = 5'b00001,
                            S_SETUP = 5'b00010,
                            S_SWAIT = 5'b00100,
                            S_ACT   = 5'b01000,
                            S_DONE  = 5'b10000} sfp_hst_t;
  sfp_hst_t    st_reg, st_next;
  logic        clk_reg, clk_next;
  logic        fa1_reg, fa2_reg, rdy1_reg, rdy2_reg;
  logic        rdStb_reg, rdStb_next, wrStb_reg, wrStb_next, oe_reg, oe_next;
  logic        swStb_reg, swStb_next, pe_reg, pe_next, cs_reg, cs_next;
  sfp_word_t   rdData_next;
  // link clock divided from sys_clk; actions on its falling edge
  assign clk_next = !clk_reg;
  always_ff @(posedge sys_clk) begin
    clk_reg <= sys_rst ? 1'b0 : clk_next;
    fa1_reg <= link.flagA;
    fa2_reg <= fa1_reg;
    rdy1_reg <= link.threadReady;
    rdy2_reg <= rdy1_reg;
  end
  assign link.linkClk = clk_reg;
  always_comb begin
    st_next     = st_reg;
    cs_next     = cs_reg;
    oe_next     = oe_reg;
    rdData_next = rdData;
    // strobes last one link cycle and change only as the link clock falls
    rdStb_next  = clk_reg ? 1'b0 : rdStb_reg;
    wrStb_next  = clk_reg ? 1'b0 : wrStb_reg;
    swStb_next  = clk_reg ? 1'b0 : swStb_reg;
    pe_next     = clk_reg ? 1'b0 : pe_reg;
    if (clk_reg) begin
      unique case (st_reg)
        S_IDLE: begin
          if (cmdValid) begin
            st_next = S_SETUP;
            cs_next = 1'b1;
            oe_next = (cmdOp == 2'h0);
          end
        end
        S_SETUP: begin
          if (cmdOp == 2'h2) begin
            swStb_next = 1'b1;
            st_next    = S_SWAIT;
          end else if (fa2_reg) begin
            rdStb_next = (cmdOp == 2'h0);
            wrStb_next = (cmdOp == 2'h1);
            pe_next    = cmdCommit;
            // head word, the one this strobe consumes
            if (cmdOp == 2'h0) begin
              rdData_next = link.dataBus;
            end
            st_next    = S_ACT;
          end
        end
        // ready synced before the strobe is stale; skip one link cycle
        S_SWAIT: begin
          st_next = S_ACT;
        end
        S_ACT: begin
          if (cmdOp != 2'h2 || rdy2_reg) begin
            st_next = S_DONE;
            cs_next = 1'b0;
            oe_next = 1'b0;
          end
        end
        S_DONE: begin
          if (!cmdValid) begin
            st_next = S_IDLE;
          end
        end
      endcase
    end
  end
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      st_reg    <= S_IDLE;
      cs_reg    <= 1'b0;
      oe_reg    <= 1'b0;
      rdStb_reg <= 1'b0;
      wrStb_reg <= 1'b0;
      swStb_reg <= 1'b0;
      pe_reg    <= 1'b0;
      rdData    <= '0;
    end else begin
      st_reg    <= st_next;
      cs_reg    <= cs_next;
      oe_reg    <= oe_next;
      rdStb_reg <= rdStb_next;
      wrStb_reg <= wrStb_next;
      swStb_reg <= swStb_next;
      pe_reg    <= pe_next;
      rdData    <= rdData_next;
    end
  end
  assign cmdDone                  = (st_reg == S_DONE);
  assign link.portChipSelectN     = !cs_reg;
  assign link.portOutputEnableN   = !oe_reg;
  assign link.portReadStrobeN     = !rdStb_reg;
  assign link.portWriteStrobeN    = !wrStb_reg;
  assign link.socketSwitchStrobeN = !swStb_reg;
  assign link.packetCommitStrobeN = !pe_reg;
  assign link.fifoSelectLines     = cmdAddr;
  assign link.dataFromHost        = cmdData;
  assign link.hostDataOe          = cs_reg && !oe_reg;
endmodule : sfp_host

// file: sfp_link_if.sv
// shared pins of the slave fifo port
// data bus resolved here from the device enable alone; host data otherwise
`timescale 1ns/100ps
interface sfp_link_if;
  import sfp_pkg::*;
  logic                 linkClk;
  logic                 portChipSelectN;
  logic                 portOutputEnableN;
  logic                 portReadStrobeN;
  logic                 portWriteStrobeN;
  logic                 socketSwitchStrobeN;
  logic                 packetCommitStrobeN;
  logic [ADDR_W-1:0]    fifoSelectLines;
  sfp_word_t            dataFromHost;
  logic                 hostDataOe;
  sfp_word_t            dataFromDevice;
  logic                 deviceDataOe;
  logic                 flagA;
  logic                 flagB;
  logic                 threadReady;
  wire sfp_word_t       dataBus = deviceDataOe ? dataFromDevice : dataFromHost;
  modport device (input linkClk, portChipSelectN, portOutputEnableN, portReadStrobeN, portWriteStrobeN,
                  socketSwitchStrobeN, packetCommitStrobeN, fifoSelectLines, dataBus,
                  output dataFromDevice, deviceDataOe, flagA, flagB, threadReady);
  modport host (output linkClk, portChipSelectN, portOutputEnableN, portReadStrobeN, portWriteStrobeN,
                socketSwitchStrobeN, packetCommitStrobeN, fifoSelectLines, dataFromHost, hostDataOe,
                input dataBus, flagA, flagB, threadReady);
endinterface : sfp_link_if

// file: sfp_link_monitor.sv
// concurrent checks on the slave fifo link pins
// assumes tb_top instantiates it beside the link interface
`timescale 1ns/100ps
module sfp_link_monitor (
  input wire logic              linkClk,
  input wire logic              linkRst,
  input wire logic              wideSocketMode,
  input wire logic              portChipSelectN,
  input wire logic              portOutputEnableN,
  input wire logic              portReadStrobeN,
  input wire logic              portWriteStrobeN,
  input wire logic              socketSwitchStrobeN,
  input wire logic              packetCommitStrobeN,
  input wire logic [4:0]        fifoSelectLines,
  input wire logic              hostDataOe,
  input wire logic              deviceDataOe,
  input wire logic              flagA,
  input wire logic              threadReady
);
  default clocking cb @(posedge linkClk); endclocking
  default disable iff (linkRst);
  oe_drives_a: assert property (!portChipSelectN && !portOutputEnableN |-> deviceDataOe)
    else $error("bus idle under output enable");
  oe_only_a: assert property (deviceDataOe |-> !portChipSelectN && !portOutputEnableN)
    else $error("bus driven without output enable");
  no_contention_a: assert property (!(deviceDataOe && hostDataOe))
    else $error("both ends drive the bus");
  read_qual_a: assert property (!portReadStrobeN |-> !portOutputEnableN && !portChipSelectN)
    else $error("read strobe without oe or select");
  write_qual_a: assert property (!portWriteStrobeN |-> hostDataOe && !portChipSelectN)
    else $error("write strobe without data or select");
  read_addr_hold_a: assert property ($fell(portReadStrobeN) |-> $stable(fifoSelectLines))
    else $error("address moved during read");
  commit_hold_a: assert property (!packetCommitStrobeN |-> $stable(fifoSelectLines))
    else $error("address moved during commit");
  commit_select_a: assert property (!packetCommitStrobeN |-> !portChipSelectN)
    else $error("commit without select");
  flag_gate_a: assert property ($fell(portReadStrobeN) || $fell(portWriteStrobeN) |-> $past(flagA))
    else $error("strobe while flag low");
  switch_wait_a: assert property (wideSocketMode && $fell(socketSwitchStrobeN) |=> !threadReady[*2])
    else $error("ready too early after switch");
  switch_done_a: assert property (wideSocketMode && $fell(socketSwitchStrobeN) |-> ##[1:40] threadReady)
    else $error("ready late after switch");
endmodule : sfp_link_monitor

// file: sfp_pkg.sv
// constants and types shared by both ends of the synchronous slave fifo port
// assumes both ends sit on one shared interface clocked by the link clock
package sfp_pkg;
  localparam int DATA_W          = 32;
  localparam int ADDR_W          = 5;
  localparam int THREADS         = 4;
  localparam int THR_W           = 2;
  localparam int DEPTH           = 8;
  localparam int PTR_W           = 3;
  localparam int CNT_W           = 4;
  localparam logic [CNT_W-1:0] PARTIAL_LEVEL = 4'h4;
  localparam int SWITCH_DELAY    = 4;
  localparam int FLAG_DELAY      = 1;
  localparam int HOST_DIV        = 2;
  typedef enum logic [1:0] {FLAG_EMPTY = 2'h0, FLAG_FULL = 2'h1, FLAG_PARTIAL = 2'h2} sfp_flag_mode_t;
  typedef logic [DATA_W-1:0] sfp_word_t;
endpackage : sfp_pkg

// file: tb_top.sv
// self-checking bench: host and device ends joined by the link
// assumes the host derives the link clock from sys_clk
`timescale 1ns/100ps
module tb_top;
  import sfp_pkg::*;
  logic           sys_clk = 0, sys_rst = 1, linkRst = 1;
  sfp_flag_mode_t flagAMode = FLAG_FULL, flagBMode = FLAG_EMPTY;
  logic           flagADedicated = 0, wideSocketMode = 1, cmdValid = 0, cmdCommit = 0, cmdDone, commitToggle;
  logic [THR_W-1:0] flagAThread = '0, commitThread;
  logic [1:0]     cmdOp = '0;
  logic [ADDR_W-1:0] cmdAddr = '0;
  logic [CNT_W-1:0] commitCount;
  sfp_word_t      cmdData = '0, rdData, seen;
  int             mismatches = 0, num_checks = 0;
  sfp_link_if link();
  always #5 sys_clk = ~sys_clk;
  sfp_device u_sfp_device (.link(link), .sys_clk(sys_clk), .sys_rst(sys_rst), .linkRst(linkRst),
    .flagAMode(flagAMode), .flagADedicated(flagADedicated), .flagAThread(flagAThread), .flagBMode(flagBMode),
    .wideSocketMode(wideSocketMode), .commitToggle(commitToggle), .commitThread(commitThread),
    .commitCount(commitCount));
  sfp_host u_sfp_host (.link(link), .sys_clk(sys_clk), .sys_rst(sys_rst), .cmdOp(cmdOp), .cmdValid(cmdValid),
    .cmdAddr(cmdAddr), .cmdData(cmdData), .cmdCommit(cmdCommit), .cmdDone(cmdDone), .rdData(rdData));
  sfp_link_monitor u_sfp_link_monitor (.linkClk(link.linkClk), .linkRst(linkRst),
    .wideSocketMode(wideSocketMode), .portChipSelectN(link.portChipSelectN),
    .portOutputEnableN(link.portOutputEnableN), .portReadStrobeN(link.portReadStrobeN),
    .portWriteStrobeN(link.portWriteStrobeN), .socketSwitchStrobeN(link.socketSwitchStrobeN),
    .packetCommitStrobeN(link.packetCommitStrobeN), .fifoSelectLines(link.fifoSelectLines),
    .hostDataOe(link.hostDataOe), .deviceDataOe(link.deviceDataOe), .flagA(link.flagA),
    .threadReady(link.threadReady));
  // word on the bus at the read capture edge
  always @(posedge link.linkClk) if (!link.portChipSelectN && !link.portReadStrobeN) seen <= link.dataBus;
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic close_out;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : close_out
  task automatic host_cmd(input logic [1:0] op, input logic [ADDR_W-1:0] a, input sfp_word_t d, input logic c);
    int n;
    n = 0;
    cmdOp = op; cmdAddr = a; cmdData = d; cmdCommit = c; cmdValid = 1;
    while (cmdDone !== 1'b1 && n < 300) begin @(negedge sys_clk); n++; end
    check("cmdDone", {31'h0, cmdDone}, 32'h0000_0001);
    cmdValid = 0;
    n = 0;
    while (cmdDone === 1'b1 && n < 20) begin @(negedge sys_clk); n++; end
  endtask : host_cmd
  task automatic flag_modes;
    sfp_flag_mode_t m[3] = '{FLAG_EMPTY, FLAG_FULL, FLAG_PARTIAL};
    logic           e[3] = '{1'b0, 1'b1, 1'b1};
    flagADedicated = 1;
    for (int i = 0; i < 3; i++) begin
      flagBMode = m[i]; flagAMode = m[i];
      repeat (10) @(negedge sys_clk);
      check("flagB", {31'h0, link.flagB}, {31'h0, e[i]});
      check("flagA", {31'h0, link.flagA}, {31'h0, e[i]});
    end
    flagADedicated = 0;
  endtask : flag_modes
  task automatic write_commit;
    logic old;
    int   n;
    flagAMode = FLAG_FULL;
    repeat (8) @(negedge sys_clk);
    old = commitToggle;
    for (int i = 0; i < 3; i++) host_cmd(2'h1, 5'h00, 32'hA5A5_0000 + i, i == 2);
    n = 0;
    while (commitToggle === old && n < 100) begin @(negedge sys_clk); n++; end
    check("commitToggle", {31'h0, commitToggle}, {31'h0, ~old});
    check("commitCount", {28'h0, commitCount}, 32'h0000_0003);
    check("commitThread", {30'h0, commitThread}, 32'h0000_0000);
  endtask : write_commit
  task automatic switch_read;
    int n;
    n = 0;
    host_cmd(2'h2, 5'h00, 32'h0000_0000, 1'b0);
    while (link.threadReady !== 1'b1 && n < 200) begin @(negedge sys_clk); n++; end
    check("threadReady", {31'h0, link.threadReady}, 32'h0000_0001);
    flagAMode = FLAG_EMPTY;
    repeat (8) @(negedge sys_clk);
    host_cmd(2'h0, 5'h00, 32'h0000_0000, 1'b0);
    check("rdData", rdData, 32'hA5A5_0000);
    check("seen", seen, 32'hA5A5_0000);
    host_cmd(2'h0, 5'h00, 32'h0000_0000, 1'b0);
    check("rdData", rdData, 32'hA5A5_0001);
    check("seen", seen, 32'hA5A5_0001);
  endtask : switch_read
  task automatic narrow_commit;
    logic old;
    int   n;
    flagAMode = FLAG_FULL;
    wideSocketMode = 0;
    repeat (8) @(negedge sys_clk);
    old = commitToggle;
    host_cmd(2'h1, 5'h02, 32'h5A5A_0001, 1'b1);
    check("threadReady", {31'h0, link.threadReady}, 32'h0000_0001);
    n = 0;
    while (commitToggle === old && n < 100) begin @(negedge sys_clk); n++; end
    check("commitThread", {30'h0, commitThread}, 32'h0000_0002);
    check("commitCount", {28'h0, commitCount}, 32'h0000_0001);
    old = commitToggle;
    host_cmd(2'h3, 5'h03, 32'h0000_0000, 1'b1);
    n = 0;
    while (commitToggle === old && n < 100) begin @(negedge sys_clk); n++; end
    check("commitToggle", {31'h0, commitToggle}, {31'h0, ~old});
    check("commitCount", {28'h0, commitCount}, 32'h0000_0000);
    check("commitThread", {30'h0, commitThread}, 32'h0000_0003);
  endtask : narrow_commit
  initial begin
    #300000;
    mismatches++;
    close_out();
  end
  initial begin
    repeat (2) @(negedge sys_clk);
    sys_rst = 0;
    repeat (4) @(negedge sys_clk);
    linkRst = 0;
    @(negedge sys_clk);
    flag_modes();
    write_commit();
    switch_read();
    narrow_commit();
    close_out();
  end
endmodule : tb_top
